/* File: design/xdcr_pkg.sv */
// package for the crosstalk / de-alias configuration bank: offsets, fields, resets, states
// assumes a single 40 MHz system clock and an i2c host on the serial pins
// ==========================================================================
// Function
// - in-phase crosstalk field, sixteen bits, reset zero
// - quadrature crosstalk field, sixteen bits, reset zero
// - external sensor calibration temperature, upper twelve bits
// - on-chip sensor calibration temperature, lower twelve bits
// - dual phase output needs both enables set
// - flag tells which frequency phase belongs
// - second frequency select, resets to six fifths
// - beta scale six bits over sixteen, reset zero
// - alpha scale six bits, resets to unity
// - de-alias enable bit zero, resets clear
package xdcr_pkg;

	// ==========================================================================
	// register offsets
	localparam logic [7:0]  ADDR_XTALK_INPHASE   = 8'h3D;
	localparam logic [7:0]  ADDR_XTALK_QUAD      = 8'h3E;
	localparam logic [7:0]  ADDR_CAL_TEMPS       = 8'h3F;
	localparam logic [7:0]  ADDR_DEALIAS_CFG     = 8'h40;
	// arbitrary value, not tied to any real part
	localparam logic [6:0]  DEV_ADDR_DEFAULT     = 7'h2A;

	// ==========================================================================
	// field positions
	localparam int          XTALK_W              = 16;
	localparam int          TEMP_W               = 12;
	localparam int          EXT_TEMP_LSB         = 12;
	localparam int          ONCHIP_TEMP_LSB      = 0;
	localparam int          CFG_DUAL_BIT         = 22;
	localparam int          CFG_SEL_BIT          = 21;
	localparam int          CFG_BETA_LSB         = 15;
	localparam int          CFG_ALPHA_LSB        = 9;
	localparam int          CFG_RSVD_LSB         = 1;
	localparam int          CFG_EN_BIT           = 0;
	localparam int          SCALE_W              = 6;

	// ==========================================================================
	// reset values
	localparam logic [15:0] XTALK_RST            = 16'h0000;
	localparam logic [11:0] TEMP_RST             = 12'h000;
	localparam logic [23:0] DEALIAS_CFG_RST      = 24'h2021E0;
	localparam logic [5:0]  ALPHA_RST            = 6'h10;
	localparam logic [5:0]  BETA_RST             = 6'h00;
	localparam logic [7:0]  CFG_RSVD_RST         = 8'hF0;

	// ==========================================================================
	// modulation frequency codes
	typedef enum logic [1:0] {
		XDCR_FREQ_BASE      = 2'h0,
		XDCR_FREQ_SIX_SEVEN = 2'h1,
		XDCR_FREQ_SIX_FIVE  = 2'h2
	} xdcr_freq_t;

	// serial slave states, gray along addr -> ack -> regaddr -> write
	typedef enum logic [2:0] {
		XDCR_ST_IDLE    = 3'h0,
		XDCR_ST_DEVADDR = 3'h1,
		XDCR_ST_ACK     = 3'h3,
		XDCR_ST_REGADDR = 3'h2,
		XDCR_ST_WRITE   = 3'h6,
		XDCR_ST_READ    = 3'h7,
		XDCR_ST_RACK    = 3'h5,
		XDCR_ST_IGNORE  = 3'h4
	} xdcr_state_t;

	typedef enum logic [1:0] {
		XDCR_ACK_DEV  = 2'h0,
		XDCR_ACK_REG  = 2'h1,
		XDCR_ACK_DATA = 2'h2
	} xdcr_ack_t;

endpackage : xdcr_pkg

/* File: design/xdcr_freq_seq.sv */
// modulation frequency sequencer for dual-frequency phase reporting
// assumes frame_done_in is a one-cycle pulse from the depth engine on clk_sys_in
`timescale 1ns/1ps
module xdcr_freq_seq (
	input  wire logic       clk_sys_in,
	input  wire logic       reset_n_in,
	input  wire logic       frame_done_in,
	input  wire logic       dealias_en_in,
	input  wire logic       dual_en_in,
	input  wire logic       second_sel_in,
	output logic            flag_out,
	output logic [1:0]      freq_code_out
);

	logic       dual_active;
	logic       flag_reg;
	logic       flag_next;
	logic [1:0] code_reg;
	logic [1:0] code_next;

	// ==========================================================================
	// frame alternation
	// dual needs both
	assign dual_active = dealias_en_in & dual_en_in;

	always_comb
	begin
		flag_next = flag_reg;
		if (!dual_active)
			flag_next = 1'b0;
		else if (frame_done_in)
			flag_next = ~flag_reg;
		if (flag_next)
			code_next = second_sel_in ? xdcr_pkg::XDCR_FREQ_SIX_FIVE
			                          : xdcr_pkg::XDCR_FREQ_SIX_SEVEN;
		else
			code_next = xdcr_pkg::XDCR_FREQ_BASE;
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			flag_reg <= 1'b0;
			code_reg <= xdcr_pkg::XDCR_FREQ_BASE;
		end
		else
		begin
			flag_reg <= flag_next;
			code_reg <= code_next;
		end
	end

	assign flag_out      = flag_reg;
	assign freq_code_out = code_reg;

	// ==========================================================================
	// checks
	sequence dual_frame_s;
		dual_active && frame_done_in;
	endsequence

	flag_toggle_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		dual_frame_s |=> flag_out != $past(flag_out))
		else $error("flag did not toggle on dual frame");

	flag_base_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		!dual_active |=> !flag_out && freq_code_out == 2'h0)
		else $error("base frequency not held outside dual mode");

	freq_code_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		flag_out |-> freq_code_out == (second_sel_in ? 2'h2 : 2'h1)
		|| $changed(second_sel_in))
		else $error("second frequency code wrong");

endmodule : xdcr_freq_seq

/* File: design/xdcr_regs.sv */
// crosstalk and de-alias configuration bank behind an i2c slave
// assumes open-drain scl/sda resolved outside; sda_oe_out high pulls sda low
`timescale 1ns/1ps
module xdcr_regs #(
	parameter logic [6:0] DEV_ADDR = xdcr_pkg::DEV_ADDR_DEFAULT
) (
	input  wire logic        clk_sys_in,
	input  wire logic        reset_n_in,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_out,
	input  wire logic        frame_done_in,
	output logic [15:0]      internal_crosstalk_inphase_out,
	output logic [15:0]      internal_crosstalk_quadrature_out,
	output logic [11:0]      ext_sensor_cal_temp_ch2_low_out,
	output logic [11:0]      onchip_sensor_cal_temp_ch2_low_out,
	output logic             dealias_measure_enable_out,
	output logic             dual_frequency_phase_enable_out,
	output logic             second_frequency_select_out,
	output logic [5:0]       dealias_internal_beta_out,
	output logic [5:0]       dealias_internal_alpha_out,
	output logic             current_frequency_flag_out,
	output logic [1:0]       current_frequency_flag_code_out
);

	// ==========================================================================
	// storage
	logic [15:0]             inphase_reg;
	logic [15:0]             quad_reg;
	logic [11:0]             ext_temp_reg;
	logic [11:0]             onchip_temp_reg;
	logic [23:0]             dcfg_reg;

	// ==========================================================================
	// serial slave state
	logic [1:0]              scl_sync_reg;
	logic [1:0]              sda_sync_reg;
	logic                    scl_d_reg;
	logic                    sda_d_reg;
	logic                    scl_rise;
	logic                    scl_fall;
	logic                    start_det;
	logic                    stop_det;
	xdcr_pkg::xdcr_state_t   state_reg;
	xdcr_pkg::xdcr_ack_t     ack_kind_reg;
	logic [2:0]              bitcnt_reg;
	logic [7:0]              shift_reg;
	logic [7:0]              rx_byte;
	logic [1:0]              byte_idx_reg;
	logic [7:0]              reg_addr_reg;
	logic                    rw_reg;
	logic                    ack_drive_reg;
	logic                    mack_reg;
	logic [23:0]             wdata_acc_reg;
	logic [23:0]             rdata_reg;
	logic                    sda_oe_reg;
	logic                    wr_commit_reg;
	logic [7:0]              wr_addr_reg;
	logic [23:0]             wr_data_reg;
	logic [23:0]             rd_word;
	logic [23:0]             rd_next_word;
	logic [7:0]              rd_next_byte;
	logic [7:0]              cur_byte;
	logic                    seen_reg;

	// ==========================================================================
	// helpers
	function automatic logic [23:0] read_word(input logic [7:0] addr);
		logic [23:0] w;
		w = 24'h000000;
		case (addr)
			xdcr_pkg::ADDR_XTALK_INPHASE: w = {8'h00, inphase_reg};
			xdcr_pkg::ADDR_XTALK_QUAD:    w = {8'h00, quad_reg};
			xdcr_pkg::ADDR_CAL_TEMPS:     w = {ext_temp_reg, onchip_temp_reg};
			xdcr_pkg::ADDR_DEALIAS_CFG:   w = dcfg_reg;
			default:                      w = 24'h000000;
		endcase
		return w;
	endfunction : read_word

	function automatic logic [7:0] byte_of(input logic [23:0] w, input logic [1:0] idx);
		logic [7:0] b;
		b = 8'h00;
		case (idx)
			2'h0:    b = w[7:0];
			2'h1:    b = w[15:8];
			default: b = w[23:16];
		endcase
		return b;
	endfunction : byte_of

	// ==========================================================================
	// pin synchronisers and line events
	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			scl_d_reg    <= 1'b1;
			sda_d_reg    <= 1'b1;
		end
		else
		begin
			scl_sync_reg <= {scl_sync_reg[0], scl_in};
			sda_sync_reg <= {sda_sync_reg[0], sda_in};
			scl_d_reg    <= scl_sync_reg[1];
			sda_d_reg    <= sda_sync_reg[1];
		end
	end

	assign scl_rise  = scl_sync_reg[1] & ~scl_d_reg;
	assign scl_fall  = ~scl_sync_reg[1] & scl_d_reg;
	assign start_det = scl_sync_reg[1] & scl_d_reg & sda_d_reg & ~sda_sync_reg[1];
	assign stop_det  = scl_sync_reg[1] & scl_d_reg & ~sda_d_reg & sda_sync_reg[1];
	assign rx_byte   = {shift_reg[6:0], sda_sync_reg[1]};

	always_comb
	begin
		rd_word      = read_word(reg_addr_reg);
		rd_next_word = read_word(reg_addr_reg + 8'h01);
		rd_next_byte = (byte_idx_reg == 2'h2) ? rd_next_word[7:0]
		                                      : byte_of(rdata_reg, byte_idx_reg + 2'h1);
		// byte on the wire; a bit of a call result cannot be selected directly
		cur_byte     = byte_of(rdata_reg, byte_idx_reg);
	end

	// ==========================================================================
	// serial protocol engine
	// words travel low byte first, each byte msb first; address auto-increments
	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			state_reg     <= xdcr_pkg::XDCR_ST_IDLE;
			ack_kind_reg  <= xdcr_pkg::XDCR_ACK_DEV;
			bitcnt_reg    <= 3'h0;
			shift_reg     <= 8'h00;
			byte_idx_reg  <= 2'h0;
			reg_addr_reg  <= 8'h00;
			rw_reg        <= 1'b0;
			ack_drive_reg <= 1'b0;
			mack_reg      <= 1'b0;
			wdata_acc_reg <= 24'h000000;
			rdata_reg     <= 24'h000000;
			sda_oe_reg    <= 1'b0;
			wr_commit_reg <= 1'b0;
			wr_addr_reg   <= 8'h00;
			wr_data_reg   <= 24'h000000;
		end
		else
		begin
			wr_commit_reg <= 1'b0;
			if (start_det)
			begin
				state_reg     <= xdcr_pkg::XDCR_ST_DEVADDR;
				bitcnt_reg    <= 3'h0;
				sda_oe_reg    <= 1'b0;
				ack_drive_reg <= 1'b0;
				mack_reg      <= 1'b0;
			end
			else if (stop_det)
			begin
				state_reg  <= xdcr_pkg::XDCR_ST_IDLE;
				sda_oe_reg <= 1'b0;
			end
			else
			begin
				case (state_reg)
					xdcr_pkg::XDCR_ST_DEVADDR, xdcr_pkg::XDCR_ST_REGADDR,
					xdcr_pkg::XDCR_ST_WRITE:
					begin
						if (scl_rise)
						begin
							shift_reg  <= rx_byte;
							bitcnt_reg <= bitcnt_reg + 3'h1;
							if (bitcnt_reg == 3'h7)
							begin
								state_reg <= xdcr_pkg::XDCR_ST_ACK;
								if (state_reg == xdcr_pkg::XDCR_ST_DEVADDR)
								begin
									ack_kind_reg <= xdcr_pkg::XDCR_ACK_DEV;
									rw_reg       <= rx_byte[0];
									// foreign address: stay off the line until the next start
									if (rx_byte[7:1] != DEV_ADDR)
										state_reg <= xdcr_pkg::XDCR_ST_IGNORE;
								end
								else if (state_reg == xdcr_pkg::XDCR_ST_REGADDR)
								begin
									ack_kind_reg <= xdcr_pkg::XDCR_ACK_REG;
									reg_addr_reg <= rx_byte;
									byte_idx_reg <= 2'h0;
								end
								else
								begin
									ack_kind_reg <= xdcr_pkg::XDCR_ACK_DATA;
									case (byte_idx_reg)
										2'h0:    wdata_acc_reg[7:0]  <= rx_byte;
										default: wdata_acc_reg[15:8] <= rx_byte;
									endcase
									if (byte_idx_reg == 2'h2)
									begin
										// a partial word is never committed
										wr_commit_reg <= 1'b1;
										wr_addr_reg   <= reg_addr_reg;
										wr_data_reg   <= {rx_byte, wdata_acc_reg[15:0]};
										reg_addr_reg  <= reg_addr_reg + 8'h01;
										byte_idx_reg  <= 2'h0;
									end
									else
										byte_idx_reg <= byte_idx_reg + 2'h1;
								end
							end
						end
					end
					xdcr_pkg::XDCR_ST_ACK:
					begin
						if (scl_fall)
						begin
							if (!ack_drive_reg)
							begin
								ack_drive_reg <= 1'b1;
								sda_oe_reg    <= 1'b1;
							end
							else
							begin
								ack_drive_reg <= 1'b0;
								bitcnt_reg    <= 3'h0;
								sda_oe_reg    <= 1'b0;
								if (ack_kind_reg == xdcr_pkg::XDCR_ACK_DEV && rw_reg)
								begin
									state_reg    <= xdcr_pkg::XDCR_ST_READ;
									rdata_reg    <= rd_word;
									byte_idx_reg <= 2'h0;
									sda_oe_reg   <= ~rd_word[7];
								end
								else if (ack_kind_reg == xdcr_pkg::XDCR_ACK_DEV)
									state_reg <= xdcr_pkg::XDCR_ST_REGADDR;
								else
									state_reg <= xdcr_pkg::XDCR_ST_WRITE;
							end
						end
					end
					xdcr_pkg::XDCR_ST_READ:
					begin
						if (scl_rise)
						begin
							bitcnt_reg <= bitcnt_reg + 3'h1;
							if (bitcnt_reg == 3'h7)
							begin
								state_reg <= xdcr_pkg::XDCR_ST_RACK;
								mack_reg  <= 1'b0;
							end
						end
						else if (scl_fall)
							sda_oe_reg <= ~cur_byte[3'h7 - bitcnt_reg];
					end
					xdcr_pkg::XDCR_ST_RACK:
					begin
						if (scl_rise)
						begin
							if (sda_sync_reg[1])
								state_reg <= xdcr_pkg::XDCR_ST_IGNORE;
							else
								mack_reg <= 1'b1;
						end
						else if (scl_fall)
						begin
							if (mack_reg)
							begin
								state_reg  <= xdcr_pkg::XDCR_ST_READ;
								mack_reg   <= 1'b0;
								bitcnt_reg <= 3'h0;
								sda_oe_reg <= ~rd_next_byte[7];
								if (byte_idx_reg == 2'h2)
								begin
									byte_idx_reg <= 2'h0;
									reg_addr_reg <= reg_addr_reg + 8'h01;
									rdata_reg    <= rd_next_word;
								end
								else
									byte_idx_reg <= byte_idx_reg + 2'h1;
							end
							else
								sda_oe_reg <= 1'b0;
						end
					end
					default:
						sda_oe_reg <= 1'b0;
				endcase
			end
		end
	end

	assign sda_out    = 1'b0;
	assign sda_oe_out = sda_oe_reg;

	// ==========================================================================
	// register file
	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			inphase_reg     <= xdcr_pkg::XTALK_RST;
			quad_reg        <= xdcr_pkg::XTALK_RST;
			ext_temp_reg    <= xdcr_pkg::TEMP_RST;
			onchip_temp_reg <= xdcr_pkg::TEMP_RST;
			dcfg_reg        <= xdcr_pkg::DEALIAS_CFG_RST;
		end
		else if (wr_commit_reg)
		begin
			case (wr_addr_reg)
				xdcr_pkg::ADDR_XTALK_INPHASE: inphase_reg <= wr_data_reg[15:0];
				xdcr_pkg::ADDR_XTALK_QUAD:    quad_reg <= wr_data_reg[15:0];
				xdcr_pkg::ADDR_CAL_TEMPS:
				begin
					ext_temp_reg    <= wr_data_reg[23:12];
					onchip_temp_reg <= wr_data_reg[11:0];
				end
				xdcr_pkg::ADDR_DEALIAS_CFG:   dcfg_reg <= wr_data_reg;
				default:                      dcfg_reg <= dcfg_reg;
			endcase
		end
	end

	// ==========================================================================
	// outputs to the depth engine
	assign internal_crosstalk_inphase_out     = inphase_reg;
	assign internal_crosstalk_quadrature_out  = quad_reg;
	assign ext_sensor_cal_temp_ch2_low_out    = ext_temp_reg;
	assign onchip_sensor_cal_temp_ch2_low_out = onchip_temp_reg;
	assign dealias_measure_enable_out         = dcfg_reg[xdcr_pkg::CFG_EN_BIT];
	assign dual_frequency_phase_enable_out    = dcfg_reg[xdcr_pkg::CFG_DUAL_BIT];
	assign second_frequency_select_out        = dcfg_reg[xdcr_pkg::CFG_SEL_BIT];
	// beta scale, lsb is one sixteenth
	assign dealias_internal_beta_out  = dcfg_reg[xdcr_pkg::CFG_BETA_LSB +: xdcr_pkg::SCALE_W];
	assign dealias_internal_alpha_out = dcfg_reg[xdcr_pkg::CFG_ALPHA_LSB +: xdcr_pkg::SCALE_W];

	xdcr_freq_seq u_freq_seq (
		.clk_sys_in    (clk_sys_in),
		.reset_n_in    (reset_n_in),
		.frame_done_in (frame_done_in),
		.dealias_en_in (dcfg_reg[xdcr_pkg::CFG_EN_BIT]),
		.dual_en_in    (dcfg_reg[xdcr_pkg::CFG_DUAL_BIT]),
		.second_sel_in (dcfg_reg[xdcr_pkg::CFG_SEL_BIT]),
		.flag_out      (current_frequency_flag_out),
		.freq_code_out (current_frequency_flag_code_out)
	);

	// ==========================================================================
	// checks
	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			seen_reg <= 1'b0;
		else
			seen_reg <= 1'b1;
	end

	sequence commit_s(logic [7:0] a);
		wr_commit_reg && wr_addr_reg == a;
	endsequence

	inphase_wr_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		commit_s(xdcr_pkg::ADDR_XTALK_INPHASE)
		|=> internal_crosstalk_inphase_out == $past(wr_data_reg[15:0]))
		else $error("in-phase field not written");

	quad_wr_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		commit_s(xdcr_pkg::ADDR_XTALK_QUAD)
		|=> internal_crosstalk_quadrature_out == $past(wr_data_reg[15:0])
		&& $stable(internal_crosstalk_inphase_out))
		else $error("quadrature field not written");

	temps_wr_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		commit_s(xdcr_pkg::ADDR_CAL_TEMPS) |=> {ext_sensor_cal_temp_ch2_low_out,
		onchip_sensor_cal_temp_ch2_low_out} == $past(wr_data_reg))
		else $error("calibration temperatures not written");

	// watched at the pin: a zero byte keeps the line pulled low for all eight bits
	xtalk_upper_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		state_reg == xdcr_pkg::XDCR_ST_READ && byte_idx_reg == 2'h2
		&& (reg_addr_reg == xdcr_pkg::ADDR_XTALK_INPHASE
		|| reg_addr_reg == xdcr_pkg::ADDR_XTALK_QUAD) |-> sda_oe_out)
		else $error("crosstalk upper bits not zero");

	cfg_reset_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		!seen_reg |-> dealias_internal_alpha_out == xdcr_pkg::ALPHA_RST
		&& dealias_internal_beta_out == xdcr_pkg::BETA_RST
		&& second_frequency_select_out && !dealias_measure_enable_out
		&& dcfg_reg[8:1] == xdcr_pkg::CFG_RSVD_RST)
		else $error("de-alias config reset value wrong");

endmodule : xdcr_regs

/* File: tb/xdcr_host_model.sv */
// i2c host model for the configuration bank's serial pins
// assumes the bench resolves the open-drain data wire with a pull-up
`timescale 1ns/1ps
module xdcr_host_model (
	input  wire logic clk_in,
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_low_out
);
	// ==========
	// bit timing
	// phases kept well above the four-cycle minimum of the synchronisers
	localparam int PH = 6;
	initial
	begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clk_in);
	endtask : tick
	// start or repeated start, entered with clock high or low
	task automatic start_cond();
		sda_low_out = 1'b0;
		tick(PH);
		scl_out = 1'b1;
		tick(PH);
		sda_low_out = 1'b1;
		tick(PH);
		scl_out = 1'b0;
		tick(2);
	endtask : start_cond
	task automatic stop_cond();
		sda_low_out = 1'b1;
		tick(PH);
		scl_out = 1'b1;
		tick(PH);
		sda_low_out = 1'b0;
		tick(PH);
	endtask : stop_cond
	// data moves two cycles after the clock fall, never with it
	task automatic bit_io(input logic b, output logic r);
		sda_low_out = ~b;
		tick(PH);
		scl_out = 1'b1;
		tick(PH);
		r = sda_in;
		scl_out = 1'b0;
		tick(2);
	endtask : bit_io
	task automatic send_byte(input logic [7:0] v, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(v[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask : send_byte
	task automatic recv_byte(input logic last, output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, v[i]);
		bit_io(last, r);
	endtask : recv_byte
endmodule : xdcr_host_model

/* File: tb/tb_xdcr_regs.sv */
// self-checking bench for the crosstalk and de-alias configuration bank
// assumes the bank's package and the host model are compiled first
`timescale 1ns/1ps
module tb_xdcr_regs;
	localparam logic [6:0] DEV = xdcr_pkg::DEV_ADDR_DEFAULT;
	logic        clk_sys_in, reset_n_in, frame_done_in, scl, sda_low, sda_oe, sda_o;
	logic [15:0] inph, quad;
	logic [11:0] ext_t, onc_t;
	logic        en, dual, sel, flag;
	logic [5:0]  beta, alpha;
	logic [1:0]  code;
	logic [23:0] mdl [4];
	logic [7:0]  bq [$];
	logic [23:0] rq [$];
	int          err_total, checks;
	wire         sda = (sda_low | (sda_oe & ~sda_o)) ? 1'b0 : 1'b1;
	always #12.5 clk_sys_in = ~clk_sys_in;
	xdcr_regs xdcr_regs_inst (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe),
		.frame_done_in(frame_done_in), .internal_crosstalk_inphase_out(inph),
		.internal_crosstalk_quadrature_out(quad), .ext_sensor_cal_temp_ch2_low_out(ext_t),
		.onchip_sensor_cal_temp_ch2_low_out(onc_t), .dealias_measure_enable_out(en),
		.dual_frequency_phase_enable_out(dual), .second_frequency_select_out(sel),
		.dealias_internal_beta_out(beta), .dealias_internal_alpha_out(alpha),
		.current_frequency_flag_out(flag), .current_frequency_flag_code_out(code));
	xdcr_host_model xdcr_host_model_inst (.clk_in(clk_sys_in), .sda_in(sda),
		.scl_out(scl), .sda_low_out(sda_low));
	// ==========
	// checks
	task automatic chk_word(input string nm, input logic [23:0] e, input logic [23:0] g);
		checks++;
		if (g !== e)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_word
	task automatic chk_out(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_out
	function automatic logic [23:0] exp_rd(input int k);
		return (k < 2) ? {8'h00, mdl[k][15:0]} : mdl[k];
	endfunction : exp_rd
	function automatic logic [1:0] exp_code(input logic f, input logic s);
		return f ? (s ? 2'h2 : 2'h1) : 2'h0;
	endfunction : exp_code
	function automatic logic [23:0] cfg_word(input logic d, input logic s,
		input logic [5:0] b, input logic [5:0] al, input logic e);
		return {1'b0, d, s, b, al, 8'hF0, e};
	endfunction : cfg_word
	task automatic chk_ports();
		chk_out("inphase", mdl[0][15:0], inph);
		chk_out("quadrature", mdl[1][15:0], quad);
		chk_out("ext temp", {4'h0, mdl[2][23:12]}, {4'h0, ext_t});
		chk_out("onchip temp", {4'h0, mdl[2][11:0]}, {4'h0, onc_t});
		chk_out("enable", {15'h0, mdl[3][0]}, {15'h0, en});
		chk_out("dual", {15'h0, mdl[3][22]}, {15'h0, dual});
		chk_out("select", {15'h0, mdl[3][21]}, {15'h0, sel});
		chk_out("beta", {10'h0, mdl[3][20:15]}, {10'h0, beta});
		chk_out("alpha", {10'h0, mdl[3][14:9]}, {10'h0, alpha});
		chk_out("idle freq", 16'h0000, {13'h0, flag, code});
	endtask : chk_ports
	// ==========
	// bus cycles
	task automatic put_word(input logic [23:0] w);
		bq.push_back(w[7:0]);
		bq.push_back(w[15:8]);
		bq.push_back(w[23:16]);
	endtask : put_word
	task automatic wr_bytes(input logic [6:0] dev, input logic [7:0] ra);
		logic a;
		xdcr_host_model_inst.start_cond();
		xdcr_host_model_inst.send_byte({dev, 1'b0}, a);
		chk_out("address ack", {15'h0, dev == DEV}, {15'h0, a});
		if (a === 1'b1)
		begin
			xdcr_host_model_inst.send_byte(ra, a);
			foreach (bq[i])
				xdcr_host_model_inst.send_byte(bq[i], a);
		end
		xdcr_host_model_inst.stop_cond();
		// only whole words at mapped offsets land
		if (dev == DEV)
			for (int k = 0; k < bq.size() / 3; k++)
				if (ra + k >= 8'h3D && ra + k <= 8'h40)
					mdl[ra + k - 8'h3D] = {bq[3*k+2], bq[3*k+1], bq[3*k]};
		bq.delete();
	endtask : wr_bytes
	task automatic rd_words(input logic [7:0] ra, input int n);
		logic a;
		logic [7:0] b0, b1, b2;
		rq.delete();
		xdcr_host_model_inst.start_cond();
		xdcr_host_model_inst.send_byte({DEV, 1'b0}, a);
		xdcr_host_model_inst.send_byte(ra, a);
		xdcr_host_model_inst.start_cond();
		xdcr_host_model_inst.send_byte({DEV, 1'b1}, a);
		for (int k = 0; k < n; k++)
		begin
			xdcr_host_model_inst.recv_byte(1'b0, b0);
			xdcr_host_model_inst.recv_byte(1'b0, b1);
			xdcr_host_model_inst.recv_byte(k == n - 1, b2);
			rq.push_back({b2, b1, b0});
		end
		xdcr_host_model_inst.stop_cond();
	endtask : rd_words
	task automatic frame(input logic ef);
		@(negedge clk_sys_in);
		frame_done_in = 1'b1;
		@(negedge clk_sys_in);
		frame_done_in = 1'b0;
		chk_out("freq flag", {15'h0, ef}, {15'h0, flag});
		chk_out("freq code", {14'h0, exp_code(ef, mdl[3][21])}, {14'h0, code});
	endtask : frame
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude
	// ==========
	// sequence
	initial
	begin
		logic [23:0] r;
		clk_sys_in = 1'b0;
		reset_n_in = 1'b0;
		frame_done_in = 1'b0;
		err_total = 0;
		checks = 0;
		mdl = '{24'h000000, 24'h000000, 24'h000000, 24'h2021E0};
		void'($urandom(5171));
		repeat (4) @(negedge clk_sys_in);
		reset_n_in = 1'b1;
		repeat (4) @(negedge clk_sys_in);
		chk_ports();
		rd_words(8'h3D, 4);
		foreach (rq[k]) chk_word("reset readback", exp_rd(k), rq[k]);
		// all-ones corner first, then random words in two bursts
		for (int n = 0; n < 3; n++)
		begin
			r = (n == 0) ? 24'hFFFFFF : 24'($urandom);
			put_word(r);
			put_word((n == 0) ? r : 24'($urandom));
			put_word((n == 0) ? r : 24'($urandom));
			put_word(cfg_word(r[0], r[1], r[7:2], r[13:8], r[14]));
			wr_bytes(DEV, 8'h3D);
			chk_ports();
			rd_words(8'h3D, 4);
			foreach (rq[k]) chk_word("readback", exp_rd(k), rq[k]);
		end
		// refused traffic: wrong device, partial word, unmapped offset
		put_word(24'h123456);
		wr_bytes(DEV ^ 7'h01, 8'h3D);
		bq = '{8'hAA, 8'h55};
		wr_bytes(DEV, 8'h3F);
		put_word(24'hABCDEF);
		wr_bytes(DEV, 8'h41);
		chk_ports();
		rd_words(8'h41, 1);
		chk_word("unmapped read", 24'h000000, rq[0]);
		for (int v = 0; v < 2; v++)
		begin
			put_word(cfg_word(1'b1, v[0], 6'h00, 6'h10, 1'b1));
			wr_bytes(DEV, 8'h40);
			for (int k = 1; k <= 4 - v; k++)
				frame(k[0]);
		end
		// flag left high, then enable dropped: single frequency again
		put_word(cfg_word(1'b1, 1'b1, 6'h00, 6'h10, 1'b0));
		wr_bytes(DEV, 8'h40);
		frame(1'b0);
		frame(1'b0);
		conclude();
	end
	initial
	begin
		repeat (90000) @(posedge clk_sys_in);
		err_total++;
		$display("[FAIL] run time expected done seen timeout");
		conclude();
	end
endmodule : tb_xdcr_regs
